/* design/drs_pkg.sv */
// constants, command codes and carrier types for the dual setting control
// assumes a 24-bit serial word, msb first, command/address/data layout
// Overview of operation
// - each channel holds a 10-bit code, 1024 taps
// - decoder output one-hot, terminal switch always closed
// - code zero selects the end-terminal tap
// - code plus one moves one tap up
// - write command loads data into addressed channel
// - address one targets second channel only
// - increment adds one, data ignored
// - save copies setting into nonvolatile store
// - restore copies store back into setting
// - global reset reloads both channels from store
// - power-on and preset pin strobe reload settings
// - 24-bit word: command, address, data, msb first
// - lowest address bit selects the channel
// - output shifts previous frame's word out
// - open-drain output disabled while select high
package drs_pkg;
  localparam int CODE_W = 10;
  localparam int TAPS = 1024;
  localparam int WORD_W = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FULL_COUNT = 5'h18;
  localparam logic [CODE_W-1:0] SETTING_RESET = 10'h000;
  localparam logic [CODE_W-1:0] STORE_RESET = 10'h200;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_SAVE = 4'h2;
  localparam logic [3:0] CMD_GLOBAL_RESET = 4'h8;
  localparam logic [3:0] CMD_WRITE = 4'hb;
  localparam logic [3:0] CMD_INCREMENT = 4'he;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } drs_word_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_EXEC = 3'b100
  } drs_state_t;
endpackage

/* design/drs_serial_port.sv */
// serial shift port on the link clock, frame bounded by select
// assumes select low frames a word; link clock may stop between frames
`timescale 1ns/10ps
module drs_serial_port
  import drs_pkg::*;
(
  // link pins
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic SDI_IN,
  // open-drain output
  output logic sdo_out,
  output logic sdo_oe_n_out,
  // captured word, stable while select is high
  output drs_word_t word_out,
  output logic complete_out
);
  logic [WORD_W-1:0] shift;
  logic [WORD_W-1:0] out_shift;
  logic [WORD_W-1:0] hold;
  logic [CNT_W-1:0] count;
  logic first;
  logic shifting;
  wire full = (count == FULL_COUNT);
  wire out_bit = shifting ? out_shift[WORD_W-1] : (first ? shift[WORD_W-1] : hold[WORD_W-1]);

  // select high arms a new frame; count is kept so the system side can read it
  always_ff @(posedge SCLK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      first <= 1'b1;
    end else begin
      first <= 1'b0;
    end
  end

  always_ff @(posedge SCLK_IN) begin
    if (!CS_N_IN) begin
      if (first) begin
        count <= 5'h01;
      end else if (!full) begin
        count <= count + 5'h01;
      end
    end
  end

  // previous word snapshot before the first new bit lands
  always_ff @(posedge SCLK_IN) begin
    if (!CS_N_IN && first) begin
      hold <= shift;
    end
  end

  always_ff @(negedge SCLK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      shifting <= 1'b0;
    end else begin
      shifting <= 1'b1;
    end
  end

  always_ff @(posedge SCLK_IN) begin
    if (!CS_N_IN) begin
      shift <= {shift[WORD_W-2:0], SDI_IN};
    end
  end

  // previous word goes out, loaded at frame start
  always_ff @(negedge SCLK_IN) begin
    if (!CS_N_IN) begin
      out_shift <= shifting ? {out_shift[WORD_W-2:0], 1'b1} : {hold[WORD_W-2:0], 1'b1};
    end
  end

  assign sdo_out = 1'b0;
  assign sdo_oe_n_out = CS_N_IN | out_bit;
  assign word_out = shift;
  assign complete_out = full;
endmodule

/* design/drs_tap_decoder.sv */
// one-hot tap decoder for one channel
// assumes code from a register on the system clock
`timescale 1ns/10ps
module drs_tap_decoder
  import drs_pkg::*;
#(
  parameter int W = CODE_W
) (
  input wire logic [W-1:0] code_in,
  output logic [(1<<W)-1:0] tap_out
);
  initial begin
    if (W < 1 || W > 16) begin
      $error("bad width");
    end
  end
  genvar i;
  for (i = 0; i < (1<<W); i++) begin : g_tap
    assign tap_out[i] = (code_in == W'(i));
  end
endmodule

/* design/drs_control.sv */
// top: dual setting control, command interpreter and settings
// assumes serial pins asynchronous to CLK_SYS_IN; preset and write-protect are pins
`timescale 1ns/10ps
module drs_control
  import drs_pkg::*;
(
  // system
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  // serial link
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_N_OUT,
  // control pins
  input wire logic PRESET_RELOAD_N_IN,
  input wire logic WRITE_PROTECT_N_IN,
  // ladder switches
  output logic [TAPS-1:0] CH0_LADDER_TAP_SWITCH_OUT,
  output logic [TAPS-1:0] CH1_LADDER_TAP_SWITCH_OUT,
  output logic [1:0] TERMINAL_SIDE_SWITCH_OUT,
  // settings
  output logic [CODE_W-1:0] FIRST_CHANNEL_SETTING_OUT,
  output logic [CODE_W-1:0] SECOND_CHANNEL_SETTING_OUT
);
  drs_word_t link_word;
  logic link_complete;

  drs_serial_port u_port (
    .SCLK_IN(SCLK_IN),
    .CS_N_IN(CS_N_IN),
    .SDI_IN(SDI_IN),
    .sdo_out(SDO_OUT),
    .sdo_oe_n_out(SDO_OE_N_OUT),
    .word_out(link_word),
    .complete_out(link_complete)
  );

  // synchronisers for select, preset, write-protect
  logic [1:0] cs_sync;
  logic [1:0] pr_sync;
  logic [1:0] wp_sync;
  logic cs_prev;
  logic pr_prev;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      cs_sync <= 2'h3;
      pr_sync <= 2'h3;
      wp_sync <= 2'h3;
      cs_prev <= 1'b1;
      pr_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], CS_N_IN};
      pr_sync <= {pr_sync[0], PRESET_RELOAD_N_IN};
      wp_sync <= {wp_sync[0], WRITE_PROTECT_N_IN};
      cs_prev <= cs_sync[1];
      pr_prev <= pr_sync[1];
    end
  end
  wire cs_rise = cs_sync[1] & ~cs_prev;
  wire pr_fall = ~pr_sync[1] & pr_prev;
  wire wp_low = ~wp_sync[1];

  // word and count are stable once select is high; sampled after the rise
  drs_state_t state;
  drs_state_t next_state;
  drs_word_t cmd_word;
  logic cmd_valid;
  logic [CODE_W-1:0] setting [2];
  // store survives system reset as a nonvolatile stand-in
  logic [CODE_W-1:0] store [2] = '{STORE_RESET, STORE_RESET};

  always_comb begin
    case (state)
      ST_LOAD: next_state = ST_IDLE;
      ST_IDLE: next_state = cs_rise ? ST_EXEC : ST_IDLE;
      ST_EXEC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      state <= ST_LOAD;
      cmd_word <= '0;
      cmd_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && cs_rise) begin
        cmd_word <= link_word;
        cmd_valid <= link_complete;
      end
    end
  end

  wire exec = (state == ST_EXEC) && cmd_valid;
  wire reload_all = (state == ST_LOAD) || pr_fall;
  wire ch = cmd_word.addr[0];
  wire [3:0] op = cmd_word.cmd;
  wire do_write = exec && op == CMD_WRITE;
  wire do_inc = exec && op == CMD_INCREMENT;
  wire do_save = exec && op == CMD_SAVE && !wp_low;
  wire do_restore = exec && op == CMD_RESTORE;
  wire do_global = exec && op[3] && op[2:0] == CMD_NOP[2:0];

  genvar c;
  for (c = 0; c < 2; c++) begin : g_ch
    wire hit = (ch == c[0]);
    logic [CODE_W-1:0] next_setting;
    always_comb begin
      next_setting = setting[c];
      if (reload_all || do_global || (do_restore && hit)) begin
        next_setting = store[c];
      end else if (do_write && hit) begin
        next_setting = cmd_word.data[CODE_W-1:0];
      end else if (do_inc && hit) begin
        next_setting = setting[c] + 10'h001;
      end
    end
    always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
        setting[c] <= SETTING_RESET;
      end else begin
        setting[c] <= next_setting;
      end
    end
    always_ff @(posedge CLK_SYS_IN) begin
      if (do_save && hit) begin
        store[c] <= setting[c];
      end
    end
  end

  drs_tap_decoder #(.W(CODE_W)) u_dec0 (
    .code_in(setting[0]),
    .tap_out(CH0_LADDER_TAP_SWITCH_OUT)
  );
  drs_tap_decoder #(.W(CODE_W)) u_dec1 (
    .code_in(setting[1]),
    .tap_out(CH1_LADDER_TAP_SWITCH_OUT)
  );

  assign TERMINAL_SIDE_SWITCH_OUT = 2'h3;
  assign FIRST_CHANNEL_SETTING_OUT = setting[0];
  assign SECOND_CHANNEL_SETTING_OUT = setting[1];
endmodule

/* sim/drs_control_props.sv */
// assertions on the dual setting control top ports
// assumes bound to drs_control, all checks on the system clock
`timescale 1ns/10ps
module drs_control_props
  import drs_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic CS_N_IN,
  input wire logic PRESET_RELOAD_N_IN,
  input wire logic SDO_OUT,
  input wire logic SDO_OE_N_OUT,
  input wire logic [TAPS-1:0] CH0_LADDER_TAP_SWITCH_OUT,
  input wire logic [TAPS-1:0] CH1_LADDER_TAP_SWITCH_OUT,
  input wire logic [1:0] TERMINAL_SIDE_SWITCH_OUT,
  input wire logic [CODE_W-1:0] FIRST_CHANNEL_SETTING_OUT,
  input wire logic [CODE_W-1:0] SECOND_CHANNEL_SETTING_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  sequence quiet_frame; (!CS_N_IN && PRESET_RELOAD_N_IN) [*8]; endsequence
  AST_ONEHOT0: assert property ($onehot(CH0_LADDER_TAP_SWITCH_OUT)) else $error("ch0 not one-hot");
  AST_ONEHOT1: assert property ($onehot(CH1_LADDER_TAP_SWITCH_OUT)) else $error("ch1 not one-hot");
  AST_DEC0: assert property (CH0_LADDER_TAP_SWITCH_OUT[FIRST_CHANNEL_SETTING_OUT]) else $error("ch0");
  AST_DEC1: assert property (CH1_LADDER_TAP_SWITCH_OUT[SECOND_CHANNEL_SETTING_OUT]) else $error("ch1");
  AST_TERMINAL: assert property (TERMINAL_SIDE_SWITCH_OUT == 2'h3) else $error("terminal open");
  AST_SDO_OFF: assert property (CS_N_IN && $past(CS_N_IN) |-> SDO_OE_N_OUT) else $error("sdo driven");
  AST_SDO_LEVEL: assert property (SDO_OUT == 1'h0) else $error("sdo level");
  AST_HOLD: assert property (quiet_frame |-> $stable(FIRST_CHANNEL_SETTING_OUT))
    else $error("setting moved in frame");
endmodule

/* sim/drs_host_model.sv */
// host serial master driving the link pins
// assumes a pull-up on the data return
`timescale 1ns/10ps
module drs_host_model (
  output logic sclk_out = 1'h0,
  output logic cs_n_out = 1'h1,
  output logic sdi_out = 1'h0,
  input wire logic sdo_pin_in,
  output logic [23:0] rx_out
);
  // clock stands low outside frames
  task automatic send(input logic [23:0] w, input int n);
    cs_n_out = 1'h0;
    for (int i = 23; i > 23 - n; i--) begin
      sdi_out = w[i];
      #3 rx_out = {rx_out[22:0], sdo_pin_in};
      sclk_out = 1'h1;
      #3 sclk_out = 1'h0;
    end
    #3 cs_n_out = 1'h1;
    sdi_out = ~sdi_out;
  endtask
endmodule

/* sim/test_dual_rheostat_setting_control.sv */
// self-checking bench for the dual setting control
// assumes host model on the link, pull-up on data return
`timescale 1ns/10ps
module test_dual_rheostat_setting_control import drs_pkg::*; ;
  logic clk = 1'h0, srst = 1'h1, pre_n = 1'h1, wp_n = 1'h1, sdo, oe_n, sclk, cs_n, sdi;
  logic [CODE_W-1:0] s0, s1;
  logic [23:0] rx;
  wire logic pin = oe_n ? 1'h1 : sdo;
  int err_total = 0, n_tests = 0;
  drs_host_model drs_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_pin_in(pin), .rx_out(rx));
  drs_control drs_control_i (.CLK_SYS_IN(clk), .SRST_IN(srst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SDI_IN(sdi),
    .SDO_OUT(sdo), .SDO_OE_N_OUT(oe_n), .PRESET_RELOAD_N_IN(pre_n), .WRITE_PROTECT_N_IN(wp_n),
    .CH0_LADDER_TAP_SWITCH_OUT(), .CH1_LADDER_TAP_SWITCH_OUT(), .TERMINAL_SIDE_SWITCH_OUT(),
    .FIRST_CHANNEL_SETTING_OUT(s0), .SECOND_CHANNEL_SETTING_OUT(s1));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [9:0] e0, input logic [9:0] e1);
    n_tests++;
    if (s0 !== e0 || s1 !== e1) begin
      err_total++;
      $display("CHECK FAILED %0t %h %h", $time, s0, s1);
    end
  endtask
  task automatic cmd(input logic [23:0] w, input int n = 24);
    @(negedge clk);
    drs_host_model_i.send(w, n);
    repeat (8) @(negedge clk);
  endtask
  task automatic t_write;
    cmd(24'hb00100);
    chk(10'h100, STORE_RESET);
    cmd(24'hb10300);
    chk(10'h100, 10'h300);
    n_tests++;
    if (rx !== 24'hb00100) begin
      err_total++;
      $display("CHECK FAILED %0t rx %h", $time, rx);
    end
    cmd(24'he00000);
    cmd(24'he0ffff);
    chk(10'h102, 10'h300);
  endtask
  task automatic t_store;
    cmd(24'h200000);
    wp_n = 1'h0;
    cmd(24'hb003ff);
    cmd(24'h200000);
    wp_n = 1'h1;
    cmd(24'h100000);
    chk(10'h102, 10'h300);
  endtask
  task automatic t_reload;
    cmd(24'hb00009);
    cmd(24'hb10009);
    cmd(24'h000000);
    cmd(24'hb00333, 23);
    chk(10'h009, 10'h009);
    cmd(24'h8f1234);
    chk(10'h102, STORE_RESET);
    cmd(24'hb00009);
    pre_n = 1'h0;
    cmd(24'h000000);
    pre_n = 1'h1;
    chk(10'h102, STORE_RESET);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'h0;
    repeat (4) @(negedge clk);
    chk(STORE_RESET, STORE_RESET);
    t_write;
    t_store;
    t_reload;
    report_and_stop;
  end
  initial begin
    #40000;
    err_total++;
    report_and_stop;
  end
endmodule
bind drs_control drs_control_props drs_control_props_i (.*);
